// [bench/qbs_link_checker.sv]
// timing assertions on the link between the two ends
`timescale 1ns/1ps
`default_nettype none
module qbs_link_checker (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic kClk,
  input wire logic readPortSelectN,
  input wire logic writePortSelectN,
  input wire logic pllDisableN,
  input wire logic qOeN,
  input wire logic readValidFlag,
  input wire logic echoClock,
  input wire logic echoClockN
);
  logic rdLast_r;
  wire rdAcc;
  // a low select right after an accepted read starts nothing
  assign rdAcc = !readPortSelectN && !rdLast_r;
  always_ff @(posedge kClk) rdLast_r <= rst ? 1'b0 : rdAcc;
  sequence rdPll;
    rdAcc && pllDisableN;
  endsequence
  sequence rdLeg;
    rdAcc && !pllDisableN;
  endsequence
  sequence burstOut;
    readValidFlag ##1 (readValidFlag && !qOeN);
  endsequence
  chk_pll_latency:
    assert property (@(posedge kClk) disable iff (rst) rdPll |-> ##2 burstOut)
    else $error("read data late or early in pll mode");
  chk_legacy_latency:
    assert property (@(posedge kClk) disable iff (rst) rdLeg |-> ##1 burstOut)
    else $error("read data late or early in legacy mode");
  chk_tri_after:
    assert property (@(posedge kClk) disable iff (rst)
      rdPll ##2 !rdAcc |-> ##2 !readValidFlag ##1 qOeN)
    else $error("outputs not released after burst");
  chk_oe_cause:
    assert property (@(posedge kClk) disable iff (rst) $fell(qOeN) |->
      (pllDisableN ? $past(rdAcc, 3) : $past(rdAcc, 2)))
    else $error("outputs driven without a read");
  chk_rd_spacing:
    assert property (@(posedge kClk) disable iff (rst)
      !readPortSelectN |=> readPortSelectN)
    else $error("read selects on adjacent rises");
  chk_wr_spacing:
    assert property (@(posedge kClk) disable iff (rst)
      !writePortSelectN |=> writePortSelectN)
    else $error("write selects on adjacent rises");
  chk_one_start:
    assert property (@(posedge kClk) disable iff (rst)
      readPortSelectN || writePortSelectN)
    else $error("both ports selected at once");
  chk_echo_low:
    assert property (@(posedge kClk) disable iff (rst)
      !echoClock && echoClockN)
    else $error("echo clocks out of phase at rise");
  chk_echo_high:
    assert property (@(negedge kClk) disable iff (rst)
      echoClock && !echoClockN)
    else $error("echo clocks out of phase at fall");
  chk_k_phase:
    assert property (@(posedge ref_clk) disable iff (rst)
      $rose(kClk) |=> kClk ##1 !kClk)
    else $error("link clock high phase not two cycles");
endmodule
`default_nettype wire

// [bench/quad_rate_burst_sram_ports_tb.sv]
// self-checking bench joining controller end and sram end
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin n_errors++; \
  $display("MISMATCH t=%0t compare failed", $time); end end
module quad_rate_burst_sram_ports_tb import qbs_pkg::*;;
  localparam int NB = DATA_W / BYTE_W;
  localparam int BW = BURST_LEN * DATA_W;
  localparam int SW = BURST_LEN * NB;
  logic ref_clk = 1'b0;
  logic rst, wrReq, rdReq, pllOn, pllResetReq;
  logic reqReady, rdDataValid, pllLocked, impCalStrobe;
  logic [ADDR_W-1:0] wrAddr, rdAddr;
  logic [BW-1:0] wrData, rdData;
  logic [SW-1:0] wrByteSelN;
  logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
  logic [BW-1:0] expQ [$];
  logic [63:0] calT0;
  int n_errors = 0;
  int checks_done = 0;
  int cyc = 0;
  int calSeen = 0;
  always #50 ref_clk = ~ref_clk;
  qbs_link_if qbs_link_if_inst ();
  qbs_sram_dev qbs_sram_dev_inst (.ref_clk(ref_clk), .rst(rst), .ce(1'b1),
    .link(qbs_link_if_inst), .pllLocked(pllLocked),
    .impCalStrobe(impCalStrobe));
  qbs_sram_ctl qbs_sram_ctl_inst (.ref_clk(ref_clk), .rst(rst), .ce(1'b1),
    .link(qbs_link_if_inst), .wrReq(wrReq), .wrAddr(wrAddr),
    .wrData(wrData), .wrByteSelN(wrByteSelN), .rdReq(rdReq),
    .rdAddr(rdAddr), .pllOn(pllOn), .pllResetReq(pllResetReq),
    .reqReady(reqReady), .rdData(rdData), .rdDataValid(rdDataValid));
  qbs_link_checker qbs_link_checker_inst (.ref_clk(ref_clk), .rst(rst),
    .kClk(qbs_link_if_inst.kClk),
    .readPortSelectN(qbs_link_if_inst.readPortSelectN),
    .writePortSelectN(qbs_link_if_inst.writePortSelectN),
    .pllDisableN(qbs_link_if_inst.pllDisableN),
    .qOeN(qbs_link_if_inst.qOeN),
    .readValidFlag(qbs_link_if_inst.readValidFlag),
    .echoClock(qbs_link_if_inst.echoClock),
    .echoClockN(qbs_link_if_inst.echoClockN));
  task automatic stop_test;
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic waitReady;
    for (int i = 0; i < 400 && reqReady !== 1'b1; i++) @(negedge ref_clk);
    `CHK(reqReady, 1'b1)
  endtask
  // called at a falling edge; the model memory is updated at issue time
  task automatic issue(input logic w, input logic [ADDR_W-1:0] a,
      input logic [BW-1:0] dat, input logic [SW-1:0] bsel);
    logic [ADDR_W-1:0] ak;
    logic [BW-1:0] e;
    waitReady();
    wrReq = w;
    rdReq = !w;
    wrAddr = a;
    rdAddr = a;
    wrData = dat;
    wrByteSelN = bsel;
    for (int k = 0; k < BURST_LEN; k++) begin
      ak = a + ADDR_W'(k);
      for (int b = 0; b < NB; b++) begin
        if (w && !bsel[k*NB+b]) begin
          mem[ak][b*BYTE_W+:BYTE_W] = dat[k*DATA_W+b*BYTE_W+:BYTE_W];
        end
      end
      e[k*DATA_W+:DATA_W] = mem[ak];
    end
    if (!w) begin
      expQ.push_back(e);
    end
    @(negedge ref_clk);
    wrReq = 1'b0;
    rdReq = 1'b0;
  endtask
  always @(negedge ref_clk) begin
    if (rdDataValid === 1'b1) begin
      if (expQ.size() == 0) begin
        n_errors++;
        $display("MISMATCH t=%0t unexpected read data", $time);
      end else begin
        `CHK(rdData, expQ.pop_front())
      end
    end
  end
  // interval taken in time, not cycles, to keep clear of edge races
  always @(posedge impCalStrobe) begin
    if (calSeen == 1) begin
      `CHK($time - calT0, 64'(IMP_CAL_CYC*4*REF_PERIOD_NS))
    end
    calT0 = $time;
    calSeen++;
  end
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 40000) begin
      n_errors++;
      $display("MISMATCH t=%0t run timed out", $time);
      stop_test();
    end
  end
  initial begin
    logic [95:0] r;
    logic [ADDR_W-1:0] a;
    int i;
    void'($urandom(10662));
    rst = 1'b1;
    wrReq = 1'b0;
    rdReq = 1'b0;
    pllOn = 1'b1;
    pllResetReq = 1'b0;
    wrAddr = '0;
    rdAddr = '0;
    wrData = '0;
    wrByteSelN = '1;
    // k runs during reset, so the link side still catches this pulse
    repeat (4) @(negedge ref_clk);
    rst = 1'b0;
    repeat (9) @(negedge ref_clk);
    for (i = 0; i < 1200 && pllLocked !== 1'b1; i++) @(negedge ref_clk);
    `CHK(pllLocked, 1'b1)
    `CHK(i > 4*LOCK_CYC-30 && i < 4*LOCK_CYC+30, 1'b1)
    // fill the array first so that no read meets unwritten words
    for (int k = 0; k < (1 << ADDR_W); k += BURST_LEN) begin
      r = {$urandom(), $urandom(), $urandom()};
      issue(1'b1, ADDR_W'(k), r[BW-1:0], '0);
    end
    for (int n = 0; n < 10; n++) begin
      if (n == 6) begin
        // the mode may only change once the last read has completed
        waitReady();
        pllOn = 1'b0;
        repeat (8) @(negedge ref_clk);
      end
      a = (n == 0) ? 8'hFE : ADDR_W'($urandom());
      r = {$urandom(), $urandom(), $urandom()};
      issue(1'b1, a, r[BW-1:0], '0);
      r = {$urandom(), $urandom(), $urandom()};
      issue(1'b1, a, r[BW-1:0], SW'($urandom()));
      issue(1'b0, a, '0, '1);
      issue(1'b0, a - 8'h01, '0, '1);
    end
    waitReady();
    pllOn = 1'b1;
    for (i = 0; i < 12000 && calSeen < 2; i++) @(negedge ref_clk);
    `CHK(calSeen >= 2, 1'b1)
    `CHK(pllLocked, 1'b1)
    waitReady();
    pllResetReq = 1'b1;
    @(negedge ref_clk);
    pllResetReq = 1'b0;
    for (i = 0; i < 100 && pllLocked !== 1'b0; i++) @(negedge ref_clk);
    `CHK(pllLocked, 1'b0)
    for (i = 0; i < 1200 && pllLocked !== 1'b1; i++) @(negedge ref_clk);
    `CHK(pllLocked, 1'b1)
    r = {$urandom(), $urandom(), $urandom()};
    issue(1'b1, 8'h10, r[BW-1:0], 8'hA5);
    issue(1'b0, 8'h10, '0, '1);
    waitReady();
    repeat (4) @(negedge ref_clk);
    `CHK(expQ.size(), 0)
    stop_test();
  end
endmodule
`default_nettype wire

// [hdl/qbs_link_if.sv]
// link between the memory controller end and the sram port end
`timescale 1ns/1ps
`default_nettype none
interface qbs_link_if import qbs_pkg::*; #(
  parameter int DW = DATA_W,
  parameter int AW = ADDR_W
);
  localparam int NB = DW / BYTE_W;
  logic kClk;
  logic readPortSelectN;
  logic writePortSelectN;
  logic pllDisableN;
  logic [AW-1:0] addr;
  logic [DW-1:0] d;
  logic [NB-1:0] byteWriteSelectN;
  logic [DW-1:0] q;
  logic qOeN;
  logic readValidFlag;
  logic echoClock;
  logic echoClockN;
  wire [DW-1:0] qBus;
  // a released bus reads as zero here; qOeN marks the high-impedance time
  assign qBus = qOeN ? {DW{1'b0}} : q;
  modport dev(input kClk, input readPortSelectN, input writePortSelectN,
    input pllDisableN, input addr, input d, input byteWriteSelectN,
    output q, output qOeN, output readValidFlag, output echoClock,
    output echoClockN);
  modport ctl(output kClk, output readPortSelectN, output writePortSelectN,
    output pllDisableN, output addr, output d, output byteWriteSelectN,
    input qBus, input readValidFlag, input echoClock, input echoClockN);
endinterface
`default_nettype wire

// [hdl/qbs_pkg.sv]
// shared constants and types for the burst sram port pair
package qbs_pkg;
  localparam int BYTE_W = 9;
  localparam int DATA_W = 18;
  localparam int ADDR_W = 8;
  localparam int BURST_LEN = 4;
  localparam int RD_LAT_PLL = 2;
  localparam int RD_LAT_LEGACY = 1;
  localparam int REF_PERIOD_NS = 100;
  localparam int LOCK_TIME_US = 20;
  localparam int LOCK_CYC = (LOCK_TIME_US * 1000 + REF_PERIOD_NS - 1)
                            / REF_PERIOD_NS;
  localparam int STOP_TIME_NS = 30;
  localparam int STOP_CYC_RAW = (STOP_TIME_NS + REF_PERIOD_NS - 1)
                                / REF_PERIOD_NS;
  localparam int STOP_CYC = (STOP_CYC_RAW < 1) ? 1 : STOP_CYC_RAW;
  localparam int IMP_CAL_CYC = 1024;
  localparam int KSTOP_DET_CYC = 16;
  localparam int KHALT_CYC = 32;
  localparam logic [1:0] PH_LOW = 2'h0;
  localparam logic [1:0] PH_RISE = 2'h1;
  localparam logic [1:0] PH_HIGH = 2'h2;
  localparam logic [1:0] PH_FALL = 2'h3;
  typedef enum logic [4:0] {
    QBS_IDLE  = 5'h01,
    QBS_ISSUE = 5'h02,
    QBS_WDATA = 5'h04,
    QBS_RD    = 5'h08,
    QBS_HALT  = 5'h10
  } qbs_ctl_state_t;
endpackage

// [hdl/qbs_sram_ctl.sv]
// controller end: makes k by division, issues one burst at a time
`timescale 1ns/1ps
`default_nettype none
module qbs_sram_ctl import qbs_pkg::*; #(
  parameter int DW = DATA_W,
  parameter int AW = ADDR_W,
  parameter int HALT_CYC = KHALT_CYC
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ce,
  qbs_link_if.ctl link,
  input wire logic wrReq,
  input wire logic [AW-1:0] wrAddr,
  input wire logic [BURST_LEN*DW-1:0] wrData,
  input wire logic [BURST_LEN*(DW/BYTE_W)-1:0] wrByteSelN,
  input wire logic rdReq,
  input wire logic [AW-1:0] rdAddr,
  input wire logic pllOn,
  input wire logic pllResetReq,
  output logic reqReady,
  output logic [BURST_LEN*DW-1:0] rdData,
  output logic rdDataValid
);
  localparam int NB = DW / BYTE_W;
  localparam int HALT_W = $clog2(HALT_CYC + 1);

  qbs_ctl_state_t state_r;
  logic [1:0] ph_r;
  logic kClk_r;
  logic rstRun_r;
  logic opWr_r;
  logic [AW-1:0] opAddr_r;
  logic [BURST_LEN*DW-1:0] wdat_r;
  logic [BURST_LEN*NB-1:0] wbw_r;
  logic [1:0] idx_r;
  logic [3:0] hCnt_r;
  logic rps_r;
  logic wps_r;
  logic pllOn_r;
  logic [AW-1:0] addr_r;
  logic [DW-1:0] d_r;
  logic [NB-1:0] bw_r;
  logic [BURST_LEN*DW-1:0] rdData_r;
  logic rdValid_r;
  logic [HALT_W-1:0] haltCnt_r;

  // k is ours, so the q sample points are known ref edges, no resync
  // a halt first lets k finish its cycle, so it always stops low
  wire run = ce && ((state_r != QBS_HALT) || (ph_r != PH_LOW));
  wire [1:0] phNxt = ph_r + 2'h1;
  wire kNxt = (phNxt == PH_RISE) || (phNxt == PH_HIGH);
  wire atSlot = run && (ph_r == PH_FALL);
  wire atMid = run && (ph_r == PH_RISE);
  wire [3:0] lat2 = pllOn_r ? 4'(2 * RD_LAT_PLL) : 4'(2 * RD_LAT_LEGACY);
  wire [3:0] hOff = hCnt_r - lat2;
  wire [2:0] wEven = {idx_r, 1'b0};
  wire [2:0] wOdd = {idx_r, 1'b1};

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pllOn_r <= 1'b1;
      rstRun_r <= 1'b1;
      // k keeps running in reset so the far end's synchroniser sees it
      if (rstRun_r) begin
        ph_r <= phNxt;
        kClk_r <= kNxt;
      end else begin
        ph_r <= PH_LOW;
        kClk_r <= 1'b0;
      end
    end else if (ce) begin
      pllOn_r <= pllOn;
      if (run) begin
        ph_r <= phNxt;
        kClk_r <= kNxt;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_r <= QBS_IDLE;
      opWr_r <= 1'b0;
      opAddr_r <= '0;
      wdat_r <= '0;
      wbw_r <= '1;
      idx_r <= 2'h0;
      hCnt_r <= 4'h0;
      rps_r <= 1'b1;
      wps_r <= 1'b1;
      addr_r <= '0;
      d_r <= '0;
      bw_r <= '1;
      rdData_r <= '0;
      rdValid_r <= 1'b0;
      haltCnt_r <= '0;
    end else if (ce) begin
      rdValid_r <= 1'b0;
      if (atSlot) begin
        rps_r <= 1'b1;
        wps_r <= 1'b1;
        bw_r <= '1;
      end
      unique case (state_r)
        QBS_IDLE: begin
          if (wrReq || rdReq) begin
            opWr_r <= wrReq;
            opAddr_r <= wrReq ? wrAddr : rdAddr;
            wdat_r <= wrData;
            wbw_r <= wrByteSelN;
            state_r <= QBS_ISSUE;
          end else if (pllResetReq) begin
            haltCnt_r <= '0;
            state_r <= QBS_HALT;
          end
        end
        QBS_ISSUE: begin
          if (atSlot) begin
            addr_r <= opAddr_r;
            idx_r <= 2'h0;
            hCnt_r <= 4'h0;
            rps_r <= opWr_r;
            wps_r <= !opWr_r;
            state_r <= opWr_r ? QBS_WDATA : QBS_RD;
          end
        end
        QBS_WDATA: begin
          if (atSlot && idx_r == 2'h2) begin
            state_r <= QBS_IDLE;
          end else if (atSlot) begin
            d_r <= wdat_r[32'(wEven)*DW +: DW];
            bw_r <= wbw_r[32'(wEven)*NB +: NB];
            hCnt_r <= 4'h1;
          end else if (atMid && hCnt_r != 4'h0) begin
            // the fall before the first data rise carries no word
            d_r <= wdat_r[32'(wOdd)*DW +: DW];
            bw_r <= wbw_r[32'(wOdd)*NB +: NB];
            idx_r <= idx_r + 2'h1;
          end
        end
        QBS_RD: begin
          if (atSlot || atMid) begin
            hCnt_r <= hCnt_r + 4'h1;
            if (hCnt_r >= lat2) begin
              rdData_r[32'(hOff[1:0])*DW +: DW] <= link.qBus;
            end
            if (hCnt_r == lat2 + 4'h3) begin
              rdValid_r <= 1'b1;
              state_r <= QBS_IDLE;
            end
          end
        end
        QBS_HALT: begin
          haltCnt_r <= haltCnt_r + HALT_W'(1);
          if (haltCnt_r == HALT_W'(HALT_CYC - 1)) begin
            state_r <= QBS_IDLE;
          end
        end
        default: state_r <= QBS_IDLE;
      endcase
    end
  end

  assign link.kClk = kClk_r;
  assign link.readPortSelectN = rps_r;
  assign link.writePortSelectN = wps_r;
  assign link.pllDisableN = pllOn_r;
  assign link.addr = addr_r;
  assign link.d = d_r;
  assign link.byteWriteSelectN = bw_r;
  assign reqReady = (state_r == QBS_IDLE);
  assign rdData = rdData_r;
  assign rdDataValid = rdValid_r;
endmodule
`default_nettype wire

// [hdl/qbs_sram_dev.sv]
// sram port end: read and write ports, forwarding, pll lock, echo clocks
// Summary of operation
// - burst of four words over two cycles
// - latency two with pll, one legacy
// - port selects sampled on k rise only
// - read select low latches read address
// - words out on k and k-bar edges
// - read right after read is ignored
// - read deselect: finish, then tri-state
// - write takes four words, stores burst
// - write right after write is ignored
// - deselected write port ignores its inputs
// - byte selects mask each stored word
// - ports independent, any location each
// - read after write returns newest data
// - both selected: arbitrate by previous start
// - both held low alternates, read first
// - controller starts at most one access per cycle
// - impedance recalibration every 1024 cycles
// - two free-running echo clocks
// - valid flag half cycle before data
// - pll locks after stable clock time
// - stopped k clock resets pll lock
// - burst walks four ascending addresses
// - powers up deselected, outputs tri-stated
`timescale 1ns/1ps
`default_nettype none
module qbs_sram_dev import qbs_pkg::*; #(
  parameter int DW = DATA_W,
  parameter int AW = ADDR_W,
  parameter int KSTOP_CYC = KSTOP_DET_CYC
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ce,
  qbs_link_if.dev link,
  output logic pllLocked,
  output logic impCalStrobe
);
  localparam int NB = DW / BYTE_W;
  localparam int DEPTH = 1 << AW;
  localparam int LOCK_W = $clog2(LOCK_CYC + 1);
  localparam int CAL_W = $clog2(IMP_CAL_CYC);
  localparam int STOP_W = $clog2(KSTOP_CYC + 1);

  logic [DW-1:0] mem [0:DEPTH-1];

  logic kRst;
  logic pllOn;
  logic relockK;
  logic togR;
  logic ackR;
  logic prevRd_r;
  logic prevWr_r;
  logic rdPend_r;
  logic [AW-1:0] rdPendAddr_r;
  logic rdNext_r;
  logic rdNextHalf_r;
  logic [AW-1:0] rdNextAddr_r;
  logic driving_r;
  logic [DW-1:0] qPos_r;
  logic [DW-1:0] qNegHold_r;
  logic wrPend_r;
  logic [AW-1:0] wrPendAddr_r;
  logic cmV_r;
  logic cmHalf_r;
  logic [AW-1:0] cmAddr_r;
  logic [DW-1:0] dPos_r;
  logic [NB-1:0] bwPos_r;
  logic [DW-1:0] dNeg_r;
  logic [NB-1:0] bwNeg_r;
  logic readValid_r;
  logic [LOCK_W-1:0] lockCnt_r;
  logic pllLocked_r;
  logic [CAL_W-1:0] calCnt_r;
  logic impCal_r;
  logic kToggle_r;
  logic togD_r;
  logic [STOP_W-1:0] stopCnt_r;
  logic relockReq_r;

  qbs_sync2 uRstSync (.clk(link.kClk), .rst(1'b0), .ce(ce), .d(rst),
    .q(kRst));
  qbs_sync2 uPllSync (.clk(link.kClk), .rst(1'b0), .ce(ce),
    .d(link.pllDisableN), .q(pllOn));
  qbs_sync2 uReqSync (.clk(link.kClk), .rst(kRst), .ce(ce),
    .d(relockReq_r), .q(relockK));
  qbs_sync2 uTogSync (.clk(ref_clk), .rst(rst), .ce(ce), .d(kToggle_r),
    .q(togR));
  qbs_sync2 uAckSync (.clk(ref_clk), .rst(rst), .ce(ce), .d(relockK),
    .q(ackR));

  function automatic logic [DW-1:0] merge(input logic [DW-1:0] old,
      input logic [DW-1:0] nw, input logic [NB-1:0] bwN);
    logic [DW-1:0] r;
    r = old;
    for (int i = 0; i < NB; i++) begin
      if (!bwN[i]) begin
        r[i*BYTE_W +: BYTE_W] = nw[i*BYTE_W +: BYTE_W];
      end
    end
    return r;
  endfunction

  // selects and byte selects are active low
  wire rdSel = !link.readPortSelectN;
  wire wrSel = !link.writePortSelectN;
  // a second start right after an accepted one is dropped
  wire rdAcc = rdSel && !prevRd_r;
  // read wins unless it was just started, so both low alternates
  wire wrAcc = wrSel && !prevWr_r && !rdAcc;
  wire rdHalfDone = rdNext_r && !rdNextHalf_r;
  wire cmHalfDone = cmV_r && !cmHalf_r;
  // burst addresses ascend from the latched one
  wire [AW-1:0] wrBase = cmAddr_r + (cmHalf_r ? AW'(2) : AW'(0));
  wire [AW-1:0] wrBase1 = wrBase + AW'(1);
  wire [AW-1:0] rdBase = rdNextAddr_r + (rdNextHalf_r ? AW'(2) : AW'(0));
  wire [AW-1:0] rdBase1 = rdBase + AW'(1);
  // write data only accepted while a burst is owed
  wire wrPosDue = wrPend_r || cmHalfDone;

  // the pair committing at this edge is merged in, so a read sees it
  function automatic logic [DW-1:0] fetch(input logic [AW-1:0] a);
    logic [DW-1:0] w;
    w = mem[a];
    if (cmV_r && a == wrBase) begin
      w = merge(w, dPos_r, bwPos_r);
    end else if (cmV_r && a == wrBase1) begin
      w = merge(w, dNeg_r, bwNeg_r);
    end
    return w;
  endfunction

  // start decode, read and write pipelines run side by side
  always_ff @(posedge link.kClk) begin
    if (kRst) begin
      prevRd_r <= 1'b0;
      prevWr_r <= 1'b0;
      rdPend_r <= 1'b0;
      wrPend_r <= 1'b0;
      rdPendAddr_r <= '0;
      wrPendAddr_r <= '0;
    end else if (ce) begin
      prevRd_r <= rdAcc;
      prevWr_r <= wrAcc;
      rdPend_r <= pllOn && rdAcc;
      wrPend_r <= wrAcc;
      if (rdAcc) begin
        rdPendAddr_r <= link.addr;
      end
      if (wrAcc) begin
        wrPendAddr_r <= link.addr;
      end
    end
  end

  always_ff @(posedge link.kClk) begin
    if (kRst) begin
      rdNext_r <= 1'b0;
      rdNextHalf_r <= 1'b0;
      rdNextAddr_r <= '0;
    end else if (ce) begin
      if (rdHalfDone) begin
        rdNextHalf_r <= 1'b1;
      end else if (pllOn && rdPend_r) begin
        rdNext_r <= 1'b1;
        rdNextHalf_r <= 1'b0;
        rdNextAddr_r <= rdPendAddr_r;
      end else if (!pllOn && rdAcc) begin
        rdNext_r <= 1'b1;
        rdNextHalf_r <= 1'b0;
        rdNextAddr_r <= link.addr;
      end else begin
        rdNext_r <= 1'b0;
      end
    end
  end

  // output pair: even word on k rise, odd word shown after k fall
  always_ff @(posedge link.kClk) begin
    if (kRst) begin
      driving_r <= 1'b0;
      qPos_r <= '0;
      qNegHold_r <= '0;
    end else if (ce) begin
      driving_r <= rdNext_r;
      if (rdNext_r) begin
        qPos_r <= fetch(rdBase);
        qNegHold_r <= fetch(rdBase1);
      end
    end
  end

  always_ff @(posedge link.kClk) begin
    if (kRst) begin
      cmV_r <= 1'b0;
      cmHalf_r <= 1'b0;
      cmAddr_r <= '0;
      dPos_r <= '0;
      bwPos_r <= '1;
    end else if (ce) begin
      if (cmHalfDone) begin
        cmHalf_r <= 1'b1;
      end else if (wrPend_r) begin
        cmV_r <= 1'b1;
        cmHalf_r <= 1'b0;
        cmAddr_r <= wrPendAddr_r;
      end else begin
        cmV_r <= 1'b0;
      end
      if (wrPosDue) begin
        dPos_r <= link.d;
        bwPos_r <= link.byteWriteSelectN;
      end
    end
  end

  // no reset on the array: contents are undefined until written
  always_ff @(posedge link.kClk) begin
    if (ce && !kRst && cmV_r) begin
      mem[wrBase] <= merge(mem[wrBase], dPos_r, bwPos_r);
      mem[wrBase1] <= merge(mem[wrBase1], dNeg_r, bwNeg_r);
    end
  end

  always_ff @(negedge link.kClk) begin
    if (kRst) begin
      dNeg_r <= '0;
      bwNeg_r <= '1;
      readValid_r <= 1'b0;
    end else if (ce) begin
      if (cmV_r) begin
        dNeg_r <= link.d;
        bwNeg_r <= link.byteWriteSelectN;
      end
      readValid_r <= rdNext_r;
    end
  end

  // lock restarts on its own after a clock stop, no pll reset needed
  always_ff @(posedge link.kClk) begin
    if (kRst || relockK || !pllOn) begin
      lockCnt_r <= '0;
      pllLocked_r <= 1'b0;
    end else if (ce) begin
      if (lockCnt_r != LOCK_W'(LOCK_CYC)) begin
        lockCnt_r <= lockCnt_r + LOCK_W'(1);
      end
      pllLocked_r <= (lockCnt_r == LOCK_W'(LOCK_CYC - 1)) || pllLocked_r;
    end
  end

  always_ff @(posedge link.kClk) begin
    if (kRst) begin
      calCnt_r <= '0;
      impCal_r <= 1'b0;
      kToggle_r <= 1'b0;
    end else if (ce) begin
      calCnt_r <= calCnt_r + CAL_W'(1);
      impCal_r <= (calCnt_r == CAL_W'(IMP_CAL_CYC - 1));
      kToggle_r <= !kToggle_r;
    end
  end

  // ref-side watchdog: no k edge for the window means the clock stopped;
  // the request holds until the k side answers, as k may be frozen
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      togD_r <= 1'b0;
      stopCnt_r <= '0;
      relockReq_r <= 1'b0;
    end else if (ce) begin
      togD_r <= togR;
      if (togR != togD_r) begin
        stopCnt_r <= '0;
      end else if (stopCnt_r != STOP_W'(KSTOP_CYC)) begin
        stopCnt_r <= stopCnt_r + STOP_W'(1);
      end
      if (ackR) begin
        relockReq_r <= 1'b0;
      end else if (stopCnt_r == STOP_W'(KSTOP_CYC)) begin
        relockReq_r <= 1'b1;
      end
    end
  end

  assign link.q = link.kClk ? qPos_r : qNegHold_r;
  assign link.qOeN = !driving_r;
  assign link.readValidFlag = readValid_r;
  assign link.echoClock = link.kClk;
  assign link.echoClockN = !link.kClk;
  assign pllLocked = pllLocked_r;
  assign impCalStrobe = impCal_r;
endmodule
`default_nettype wire

// [hdl/qbs_sync2.sv]
// two-flop level synchroniser
`timescale 1ns/1ps
`default_nettype none
module qbs_sync2 (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic d,
  output logic q
);
  logic meta_r;
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_r <= 1'b0;
      q <= 1'b0;
    end else if (ce) begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule
`default_nettype wire
